// ===== logic/i2cm_map.svh
/*
 Register offsets, field positions, reset values and bus timing counts
 of the two-wire master. Assumes a 200 MHz core clock.
*/
`ifndef I2CM_MAP_SVH
`define I2CM_MAP_SVH
// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define I2CM_OFS_TASK    12'h000
`define I2CM_OFS_EVENT   12'h004
`define I2CM_OFS_STATUS  12'h008
`define I2CM_OFS_FREQ    12'h524
`define I2CM_OFS_RXPTR   12'h534
`define I2CM_OFS_RXLIM   12'h538
`define I2CM_OFS_RXAMT   12'h53C
`define I2CM_OFS_TXPTR   12'h544
`define I2CM_OFS_TXLIM   12'h548
`define I2CM_OFS_TXAMT   12'h54C
`define I2CM_OFS_ADDR    12'h588
// ----------------------------------------
// Task and event bit positions
// ----------------------------------------
`define I2CM_T_RD   0
`define I2CM_T_WR   1
`define I2CM_T_STP  2
`define I2CM_T_SUS  3
`define I2CM_T_RES  4
`define I2CM_E_STP  0
`define I2CM_E_ERR  1
`define I2CM_E_SUS  2
`define I2CM_E_RXB  3
`define I2CM_E_TXB  4
`define I2CM_E_FRX  5
`define I2CM_E_FTX  6
// ----------------------------------------
// Reset values and timing
// ----------------------------------------
`define I2CM_RST_FREQ  2'h0
`define I2CM_RST_ADDR  7'h00
`define I2CM_CLK_HZ    200000000
`define I2CM_KBPS_A    100
`define I2CM_KBPS_B    250
`define I2CM_KBPS_C    400
`define I2CM_QTR_A  10'(`I2CM_CLK_HZ / (4 * `I2CM_KBPS_A * 1000))
`define I2CM_QTR_B  10'(`I2CM_CLK_HZ / (4 * `I2CM_KBPS_B * 1000))
`define I2CM_QTR_C  10'(`I2CM_CLK_HZ / (4 * `I2CM_KBPS_C * 1000))
`endif

// ===== logic/i2cm_pkg.sv
/*
 Types of the two-wire master: sequencer states and frame kinds.
 Assumes nothing of its surroundings.
*/
package i2cm_pkg;
  typedef enum logic [4:0] {
    S_IDLE  = 5'h01,
    S_START = 5'h02,
    S_BIT   = 5'h04,
    S_HOLD  = 5'h08,
    S_STOP  = 5'h10
  } i2cm_state_t;
  typedef enum logic [1:0] {
    K_ADDR = 2'h0,
    K_TX   = 2'h1,
    K_RX   = 2'h2
  } i2cm_kind_t;
endpackage

// ===== logic/i2cm_top.sv
/*
 Two-wire bus master with DMA byte channels, Avalon-MM register slave.
 Assumes an Avalon memory slave on the mem_ port and pull-ups on SCL/SDA.
*/
// Decided for this implementation: the register offsets and the Avalon-MM register port.
`include "i2cm_map.svh"
`timescale 1ns/1ps
module i2cm_top import i2cm_pkg::*; (
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic [11:0] avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  output logic      [31:0] mem_address,
  output logic             mem_read,
  output logic             mem_write,
  output logic      [7:0]  mem_writedata,
  input  wire logic [7:0]  mem_readdata,
  input  wire logic        mem_waitrequest,
  input  wire logic [4:0]  task_pulse,
  output logic      [6:0]  event_pulse,
  input  wire logic        scl_in,
  output logic             scl_out,
  output logic             scl_oe,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe
);
  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  i2cm_state_t st_reg;
  i2cm_kind_t  kind_reg;
  logic [1:0]  phase_reg;
  logic [3:0]  bitn_reg;
  logic [8:0]  sh_reg;
  logic [9:0]  qcnt_reg;
  logic [9:0]  qlim;
  logic        tick;
  logic [2:0]  scl_s_reg;
  logic [2:0]  sda_s_reg;
  logic        scl_f_reg;
  logic        sda_f_reg;
  logic        rd_done_reg;
  logic [31:0] rdata_next;
  logic [31:0] bem;
  logic [31:0] wd;
  logic [4:0]  tsk;
  logic [1:0]  freq_reg;
  logic [6:0]  addr_reg;
  logic [31:0] txp_sh_reg;
  logic [31:0] rxp_sh_reg;
  logic [7:0]  txl_sh_reg;
  logic [7:0]  rxl_sh_reg;
  logic [31:0] txp_act_reg;
  logic [31:0] rxp_act_reg;
  logic [7:0]  txl_act_reg;
  logic [7:0]  rxl_act_reg;
  logic [7:0]  tx_cnt_reg;
  logic [7:0]  rx_cnt_reg;
  logic [7:0]  fcnt_reg;
  logic [7:0]  txdata_reg;
  logic        tx_have_reg;
  logic        dir_reg;
  logic        err_reg;
  logic        susp_reg;
  logic        susp_pend_reg;
  logic        stop_pend_reg;
  logic        stop_done_reg;
  logic [6:0]  ev_reg;
  logic [6:0]  ev_set;
  logic        mem_busy;
  logic        ready_op;
  logic        acc_wr;
  logic        acc_rd;
  logic        frame_end;
  logic        go_stop;
  logic        go_susp;
  logic        go_tx;
  logic        go_rx;
  logic        scl_oe_next;
  logic        sda_oe_next;

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      scl_s_reg <= 3'h7;
      sda_s_reg <= 3'h7;
      scl_f_reg <= 1'b1;
      sda_f_reg <= 1'b1;
    end else begin
      scl_s_reg <= {scl_s_reg[1:0], scl_in};
      sda_s_reg <= {sda_s_reg[1:0], sda_in};
      if (scl_s_reg[1] == scl_s_reg[2]) scl_f_reg <= scl_s_reg[2];
      if (sda_s_reg[1] == sda_s_reg[2]) sda_f_reg <= sda_s_reg[2];
    end
  end

  // ----------------------------------------
  // Avalon slave
  // ----------------------------------------
  assign avs_waitrequest = avs_read & ~rd_done_reg;
  assign bem = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  assign wd  = avs_writedata & bem;
  assign tsk = task_pulse | ((avs_write && avs_address == `I2CM_OFS_TASK) ? wd[4:0] : 5'h00);

  always_comb begin
    rdata_next = 32'h00000000;
    case (avs_address)
      `I2CM_OFS_EVENT:  rdata_next = {25'h0000000, ev_reg};
      `I2CM_OFS_STATUS: rdata_next = {28'h0000000, dir_reg, err_reg, susp_reg, st_reg != S_IDLE};
      `I2CM_OFS_FREQ:   rdata_next = {30'h00000000, freq_reg};
      `I2CM_OFS_RXPTR:  rdata_next = rxp_sh_reg;
      `I2CM_OFS_RXLIM:  rdata_next = {24'h000000, rxl_sh_reg};
      `I2CM_OFS_RXAMT:  rdata_next = {24'h000000, rx_cnt_reg};
      `I2CM_OFS_TXPTR:  rdata_next = txp_sh_reg;
      `I2CM_OFS_TXLIM:  rdata_next = {24'h000000, txl_sh_reg};
      `I2CM_OFS_TXAMT:  rdata_next = {24'h000000, tx_cnt_reg};
      `I2CM_OFS_ADDR:   rdata_next = {25'h0000000, addr_reg};
      default:          rdata_next = 32'h00000000;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      rd_done_reg  <= 1'b0;
      avs_readdata <= 32'h00000000;
    end else begin
      rd_done_reg  <= avs_read & ~rd_done_reg;
      if (avs_read && !rd_done_reg) avs_readdata <= rdata_next;
    end
  end

  // Settings: pointers and limits are shadows taken into use only at a begin task, FREQ and ADDR are used directly
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      freq_reg   <= `I2CM_RST_FREQ;
      addr_reg   <= `I2CM_RST_ADDR;
      txp_sh_reg <= 32'h00000000;
      rxp_sh_reg <= 32'h00000000;
      txl_sh_reg <= 8'h00;
      rxl_sh_reg <= 8'h00;
    end else if (avs_write) begin
      case (avs_address)
        `I2CM_OFS_FREQ:  freq_reg   <= (freq_reg & ~bem[1:0]) | wd[1:0];
        `I2CM_OFS_ADDR:  addr_reg   <= (addr_reg & ~bem[6:0]) | wd[6:0];
        `I2CM_OFS_TXPTR: txp_sh_reg <= (txp_sh_reg & ~bem) | wd;
        `I2CM_OFS_RXPTR: rxp_sh_reg <= (rxp_sh_reg & ~bem) | wd;
        `I2CM_OFS_TXLIM: txl_sh_reg <= (txl_sh_reg & ~bem[7:0]) | wd[7:0];
        `I2CM_OFS_RXLIM: rxl_sh_reg <= (rxl_sh_reg & ~bem[7:0]) | wd[7:0];
        default: ;
      endcase
    end
  end

  // Sticky events, a new event wins over a clear
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      ev_reg      <= 7'h00;
      event_pulse <= 7'h00;
    end else begin
      event_pulse <= ev_set;
      if (avs_write && avs_address == `I2CM_OFS_EVENT)
        ev_reg <= event_pulse | (ev_reg & ~wd[6:0]);
      else
        ev_reg <= event_pulse | ev_reg;
    end
  end

  // ----------------------------------------
  // Bit timing
  // ----------------------------------------
  always_comb begin
    case (freq_reg)
      2'h1:    qlim = `I2CM_QTR_B;
      2'h2:    qlim = `I2CM_QTR_C;
      default: qlim = `I2CM_QTR_A;
    endcase
  end
  assign tick = (qcnt_reg >= qlim - 10'h001);

  always_ff @(posedge core_clk) begin
    if (!rst_n) qcnt_reg <= 10'h000;
    else if (tick) qcnt_reg <= 10'h000;
    else qcnt_reg <= qcnt_reg + 10'h001;
  end

  // ----------------------------------------
  // Sequencing decisions
  // ----------------------------------------
  assign mem_busy  = mem_read | mem_write;
  assign ready_op  = (st_reg == S_HOLD) && !susp_reg && !susp_pend_reg && !stop_pend_reg;
  assign acc_wr    = tsk[`I2CM_T_WR] && !susp_reg &&
                     (st_reg == S_IDLE || st_reg == S_HOLD);
  assign acc_rd    = tsk[`I2CM_T_RD] && !tsk[`I2CM_T_WR] && !susp_reg &&
                     (st_reg == S_IDLE || st_reg == S_HOLD);
  assign frame_end = (st_reg == S_BIT) && tick && phase_reg == 2'h3 && bitn_reg == 4'h8;
  assign go_stop   = (st_reg == S_HOLD) && stop_pend_reg && !acc_wr && !acc_rd &&
                     !(dir_reg && !err_reg && rx_cnt_reg + 8'h01 == rxl_act_reg);
  assign go_susp   = (st_reg == S_HOLD) && susp_pend_reg && !stop_pend_reg &&
                     !acc_wr && !acc_rd;
  assign go_tx     = ready_op && !dir_reg && !err_reg && tx_have_reg && !acc_wr && !acc_rd &&
                     tx_cnt_reg < txl_act_reg;
  assign go_rx     = (st_reg == S_HOLD) && !susp_reg && !susp_pend_reg && dir_reg &&
                     !err_reg && !mem_busy && !acc_wr && !acc_rd && rx_cnt_reg < rxl_act_reg &&
                     (!stop_pend_reg || rx_cnt_reg + 8'h01 == rxl_act_reg);

  always_comb begin
    ev_set = 7'h00;
    ev_set[`I2CM_E_STP] = (st_reg == S_IDLE) && stop_done_reg && !mem_busy;
    ev_set[`I2CM_E_ERR] = frame_end && kind_reg != K_RX && sda_f_reg;
    ev_set[`I2CM_E_SUS] = go_susp;
    ev_set[`I2CM_E_RXB] = acc_rd;
    ev_set[`I2CM_E_TXB] = acc_wr;
    ev_set[`I2CM_E_FRX] = frame_end && ((kind_reg == K_ADDR && dir_reg && !sda_f_reg &&
                          rxl_act_reg == 8'h01) || (kind_reg == K_RX &&
                          rx_cnt_reg + 8'h02 == rxl_act_reg));
    ev_set[`I2CM_E_FTX] = go_tx && tx_cnt_reg + 8'h01 == txl_act_reg;
  end

  // ----------------------------------------
  // Bus sequencer
  // ----------------------------------------
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      st_reg <= S_IDLE;
      kind_reg <= K_ADDR;
      phase_reg <= 2'h0;
      bitn_reg <= 4'h0;
      sh_reg <= 9'h1FF;
      dir_reg <= 1'b0;
      err_reg <= 1'b0;
      tx_cnt_reg <= 8'h00;
      rx_cnt_reg <= 8'h00;
      txp_act_reg <= 32'h00000000;
      rxp_act_reg <= 32'h00000000;
      txl_act_reg <= 8'h00;
      rxl_act_reg <= 8'h00;
    end else if (acc_wr || acc_rd) begin
      st_reg <= S_START;
      phase_reg <= 2'h0;
      dir_reg <= acc_rd;
      err_reg <= 1'b0;
      if (acc_wr) begin
        txp_act_reg <= txp_sh_reg;
        txl_act_reg <= txl_sh_reg;
        tx_cnt_reg <= 8'h00;
      end else begin
        rxp_act_reg <= rxp_sh_reg;
        rxl_act_reg <= rxl_sh_reg;
        rx_cnt_reg <= 8'h00;
      end
    end else if (go_stop) begin
      st_reg <= S_STOP;
      phase_reg <= 2'h0;
    end else if (go_tx || go_rx) begin
      st_reg <= S_BIT;
      kind_reg <= go_tx ? K_TX : K_RX;
      phase_reg <= 2'h0;
      bitn_reg <= 4'h0;
      sh_reg <= go_tx ? {txdata_reg, 1'b1} :
                {8'hFF, rx_cnt_reg + 8'h01 == rxl_act_reg};
    end else if (tick && st_reg != S_IDLE && st_reg != S_HOLD) begin
      if (phase_reg == 2'h2 && !scl_f_reg) begin
        phase_reg <= 2'h2;
      end else if (phase_reg != 2'h3) begin
        phase_reg <= phase_reg + 2'h1;
      end else begin
        phase_reg <= 2'h0;
        case (st_reg)
          S_START: begin
            st_reg <= S_BIT;
            kind_reg <= K_ADDR;
            bitn_reg <= 4'h0;
            sh_reg <= {addr_reg, dir_reg, 1'b1};
          end
          S_BIT: begin
            sh_reg <= {sh_reg[7:0], sda_f_reg};
            bitn_reg <= bitn_reg + 4'h1;
            if (bitn_reg == 4'h8) begin
              st_reg <= S_HOLD;
              if (kind_reg != K_RX && sda_f_reg) err_reg <= 1'b1;
              if (kind_reg == K_TX) tx_cnt_reg <= tx_cnt_reg + 8'h01;
              if (kind_reg == K_RX) rx_cnt_reg <= rx_cnt_reg + 8'h01;
            end
          end
          S_STOP:  st_reg <= S_IDLE;
          default: st_reg <= S_IDLE;
        endcase
      end
    end
  end

  // Stop, suspend and resume bookkeeping
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      stop_pend_reg <= 1'b0;
      stop_done_reg <= 1'b0;
      susp_reg <= 1'b0;
      susp_pend_reg <= 1'b0;
    end else begin
      if (tsk[`I2CM_T_STP] && !susp_reg) stop_pend_reg <= 1'b1;
      else if (go_stop || st_reg == S_IDLE) stop_pend_reg <= 1'b0;
      if (ev_set[`I2CM_E_STP]) stop_done_reg <= 1'b0;
      else if ((st_reg == S_IDLE && stop_pend_reg) ||
               (st_reg == S_STOP && tick && phase_reg == 2'h3)) stop_done_reg <= 1'b1;
      if (tsk[`I2CM_T_RES]) begin
        susp_reg <= 1'b0;
        susp_pend_reg <= 1'b0;
      end else if (go_susp) begin
        susp_reg <= 1'b1;
        susp_pend_reg <= 1'b0;
      end else if (tsk[`I2CM_T_SUS] && st_reg != S_IDLE && !susp_reg) begin
        susp_pend_reg <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // DMA channels
  // ----------------------------------------
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      mem_read <= 1'b0;
      mem_write <= 1'b0;
      mem_address <= 32'h00000000;
      mem_writedata <= 8'h00;
      fcnt_reg <= 8'h00;
      txdata_reg <= 8'h00;
      tx_have_reg <= 1'b0;
    end else if (acc_wr) begin
      fcnt_reg <= 8'h00;
      tx_have_reg <= 1'b0;
    end else begin
      if (mem_read && !mem_waitrequest) begin
        mem_read <= 1'b0;
        txdata_reg <= mem_readdata;
        tx_have_reg <= 1'b1;
        fcnt_reg <= fcnt_reg + 8'h01;
      end else if (go_tx) begin
        tx_have_reg <= 1'b0;
      end
      if (mem_write && !mem_waitrequest) mem_write <= 1'b0;
      if (frame_end && kind_reg == K_RX) begin
        mem_write <= 1'b1;
        mem_address <= rxp_act_reg + {24'h000000, rx_cnt_reg};
        mem_writedata <= sh_reg[7:0];
      end else if (!dir_reg && !tx_have_reg && !mem_busy && st_reg != S_IDLE &&
                   fcnt_reg < txl_act_reg) begin
        mem_read <= 1'b1;
        mem_address <= txp_act_reg + {24'h000000, fcnt_reg};
      end
    end
  end

  // ----------------------------------------
  // Pin drive, open drain, no arbitration
  // ----------------------------------------
  always_comb begin
    case (st_reg)
      S_START: begin
        scl_oe_next = phase_reg == 2'h0;
        sda_oe_next = phase_reg == 2'h3;
      end
      S_BIT: begin
        // SCL low for two quarters, SDA moves only in the second
        scl_oe_next = phase_reg <= 2'h1;
        sda_oe_next = (phase_reg == 2'h0) ? sda_oe : !sh_reg[8];
      end
      S_HOLD: begin
        scl_oe_next = 1'b1;
        sda_oe_next = scl_oe | sda_oe;
      end
      S_STOP: begin
        scl_oe_next = phase_reg == 2'h0;
        sda_oe_next = phase_reg != 2'h3;
      end
      default: begin
        scl_oe_next = 1'b0;
        sda_oe_next = 1'b0;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      scl_oe <= 1'b0;
      sda_oe <= 1'b0;
    end else begin
      scl_oe <= scl_oe_next;
      sda_oe <= sda_oe_next;
    end
  end
  assign scl_out = 1'b0;
  assign sda_out = 1'b0;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  AST_WR_DIR: assert property (@(posedge core_clk) disable iff (!rst_n)
    acc_wr |=> st_reg == S_START && !dir_reg) else $error("write task not a write start");
  AST_RD_DIR: assert property (@(posedge core_clk) disable iff (!rst_n)
    acc_rd |=> st_reg == S_START && dir_reg) else $error("read task not a read start");
  AST_NACK_ERR: assert property (@(posedge core_clk) disable iff (!rst_n)
    frame_end && kind_reg != K_RX && sda_f_reg |=> event_pulse[`I2CM_E_ERR] && err_reg)
    else $error("nack without error event");
  AST_FTX_TIME: assert property (@(posedge core_clk) disable iff (!rst_n)
    event_pulse[`I2CM_E_FTX] |-> st_reg == S_BIT && kind_reg == K_TX && bitn_reg == 4'h0 &&
    tx_cnt_reg + 8'h01 == txl_act_reg) else $error("final tx event misplaced");
  AST_STOP_DMA: assert property (@(posedge core_clk) disable iff (!rst_n)
    event_pulse[`I2CM_E_STP] |-> !$past(mem_busy) && st_reg == S_IDLE)
    else $error("stopped event with DMA busy");
  AST_SUSP_STOP: assert property (@(posedge core_clk) disable iff (!rst_n)
    susp_reg && !stop_pend_reg && !tsk[`I2CM_T_RES] |=> !stop_pend_reg)
    else $error("stop accepted while suspended");
  AST_SHADOW: assert property (@(posedge core_clk) disable iff (!rst_n)
    !acc_wr |=> $stable(txp_act_reg) && $stable(txl_act_reg))
    else $error("active transmit setting changed mid transfer");
  AST_LAST_NACK: assert property (@(posedge core_clk) disable iff (!rst_n)
    st_reg == S_BIT && kind_reg == K_RX && bitn_reg == 4'h8 && phase_reg == 2'h2 ##1
    phase_reg == 2'h2 |-> sda_oe == (rx_cnt_reg + 8'h01 != rxl_act_reg))
    else $error("wrong ack level on received byte");
  AST_STRETCH: assert property (@(posedge core_clk) disable iff (!rst_n)
    st_reg == S_BIT && phase_reg == 2'h2 && !scl_f_reg && !go_stop |=> phase_reg == 2'h2)
    else $error("clock stretch not honoured");
  AST_STOP_REL: assert property (@(posedge core_clk) disable iff (!rst_n)
    st_reg == S_STOP && tick && phase_reg == 2'h3 |=> ##1 !scl_oe && !sda_oe)
    else $error("lines not released after stop");
endmodule

// ===== verification/i2c_master_dma_sequencer_tb_top.sv
/*
 Bench of the two-wire master: register tasks, DMA memory and slave model.
 Assumes pull-ups on SCL and SDA, resolved here from all enables.
*/
`include "i2cm_map.svh"
`timescale 1ns/1ps
module i2c_master_dma_sequencer_tb_top;
  // ----------------------------------------
  // Stimulus and checks
  // ----------------------------------------
  localparam logic [6:0] SLV = 7'h5A;
  logic        core_clk;
  logic        rst_n;
  logic [11:0] avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [31:0] mem_address;
  logic        mem_read;
  logic        mem_write;
  logic [7:0]  mem_writedata;
  logic [7:0]  mem_readdata;
  logic        mem_waitrequest;
  logic [4:0]  task_pulse;
  logic [6:0]  event_pulse;
  logic        scl_oe;
  logic        sda_oe;
  logic        scl_low;
  logic        sda_low;
  logic        slow;
  logic [7:0]  ram [0:63];
  logic [31:0] q;
  int          num_errors;
  int          compares;
  int          n_stopped;
  int          s0;
  wire         scl = !(scl_oe || scl_low);
  wire         sda = !(sda_oe || sda_low);
  i2cm_top u_dut (
    .core_clk(core_clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .mem_address(mem_address), .mem_read(mem_read), .mem_write(mem_write),
    .mem_writedata(mem_writedata), .mem_readdata(mem_readdata),
    .mem_waitrequest(mem_waitrequest), .task_pulse(task_pulse), .event_pulse(event_pulse),
    .scl_in(scl), .scl_out(), .scl_oe(scl_oe), .sda_in(sda), .sda_out(), .sda_oe(sda_oe));
  i2cm_slave_model #(.SLV_ADDR(SLV)) u_slave (
    .scl(scl), .sda(sda), .slow(slow), .sda_low(sda_low), .scl_low(scl_low));
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    mem_waitrequest <= !(mem_read || mem_write) || !mem_waitrequest;
    mem_readdata <= ram[mem_address[5:0]];
    if (mem_write && !mem_waitrequest) ram[mem_address[5:0]] <= mem_writedata;
    if (event_pulse[`I2CM_E_STP] === 1'b1) n_stopped <= n_stopped + 1;
  end
  task automatic report_and_stop();
    $display("compares %0d num_errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: value %h, wanted %h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    int n;
    n = 0;
    @(posedge core_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    do begin
      @(posedge core_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 100);
    if (avs_waitrequest !== 1'b0) num_errors++;
    r = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    bus(1'b1, a, d, q);
  endtask
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0, q);
    check(q, e);
  endtask
  task automatic pulse(input int b);
    @(posedge core_clk);
    task_pulse <= 5'h01 << b;
    @(posedge core_clk);
    task_pulse <= 5'h00;
  endtask
  task automatic wait_ev(input int b);
    int n;
    n = 0;
    @(negedge core_clk);
    while (event_pulse[b] !== 1'b1 && n < 40000) begin
      @(negedge core_clk);
      n++;
    end
    check(32'(event_pulse[b]), 32'h1);
  endtask
  initial begin
    #450000;
    num_errors++;
    report_and_stop();
  end
  initial begin
    {rst_n, avs_read, avs_write, slow} = 4'h0;
    {avs_address, avs_writedata, task_pulse} = '0;
    for (int i = 0; i < 64; i++) ram[i] = 8'(i) ^ 8'hA0;
    repeat (6) @(posedge core_clk);
    rst_n <= 1'b1;
    rd_chk(`I2CM_OFS_FREQ, 32'(`I2CM_RST_FREQ));
    rd_chk(`I2CM_OFS_ADDR, 32'(`I2CM_RST_ADDR));
    rd_chk(12'h100, 32'h0);
    wr(`I2CM_OFS_FREQ, 32'h2);
    rd_chk(`I2CM_OFS_FREQ, 32'h2);
    wr(`I2CM_OFS_ADDR, 32'(SLV));
    wr(`I2CM_OFS_TXPTR, 32'h10);
    wr(`I2CM_OFS_TXLIM, 32'h2);
    wr(`I2CM_OFS_RXPTR, 32'h20);
    wr(`I2CM_OFS_RXLIM, 32'h3);
    s0 = u_slave.n_stops;
    wr(`I2CM_OFS_TASK, 32'h1 << `I2CM_T_WR);
    wait_ev(`I2CM_E_TXB);
    wr(`I2CM_OFS_TXPTR, 32'h30);
    wait_ev(`I2CM_E_FTX);
    check(32'(u_slave.abyte), 32'({SLV, 1'b0}));
    repeat (4700) @(posedge core_clk);
    pulse(`I2CM_T_RD);
    wait_ev(`I2CM_E_FRX);
    pulse(`I2CM_T_STP);
    wait_ev(`I2CM_E_STP);
    check(32'(u_slave.abyte), 32'({SLV, 1'b1}));
    check(32'(u_slave.n_stops - s0), 32'h1);
    check(32'({scl_oe, sda_oe}), 32'h0);
    check(32'(u_slave.wr_q.size()), 32'h2);
    for (int i = 0; i < 2; i++) check(32'(u_slave.wr_q[i]), 32'(8'(16 + i) ^ 8'hA0));
    for (int i = 0; i < 3; i++) begin
      check(32'(ram[32 + i]), 32'(8'hC4 + 8'(i)));
      check(32'(u_slave.mack_q[i]), 32'(i == 2));
    end
    rd_chk(`I2CM_OFS_TXAMT, 32'h2);
    rd_chk(`I2CM_OFS_RXAMT, 32'h3);
    rd_chk(`I2CM_OFS_EVENT, 32'h79);
    wr(`I2CM_OFS_EVENT, 32'h7F);
    rd_chk(`I2CM_OFS_EVENT, 32'h0);
    wr(`I2CM_OFS_ADDR, 32'(SLV ^ 7'h01));
    pulse(`I2CM_T_WR);
    wait_ev(`I2CM_E_ERR);
    pulse(`I2CM_T_STP);
    wait_ev(`I2CM_E_STP);
    check(32'(u_slave.wr_q.size()), 32'h2);
    wr(`I2CM_OFS_ADDR, 32'(SLV));
    wr(`I2CM_OFS_TXLIM, 32'h3);
    slow <= 1'b1;
    pulse(`I2CM_T_WR);
    pulse(`I2CM_T_SUS);
    wait_ev(`I2CM_E_SUS);
    s0 = n_stopped;
    pulse(`I2CM_T_STP);
    repeat (2000) @(posedge core_clk);
    check(32'(n_stopped - s0), 32'h0);
    check(32'(scl_oe), 32'h1);
    check(32'(u_slave.wr_q.size()), 32'h2);
    bus(1'b0, `I2CM_OFS_STATUS, 32'h0, q);
    check(32'(q[1]), 32'h1);
    pulse(`I2CM_T_RES);
    wait_ev(`I2CM_E_FTX);
    pulse(`I2CM_T_STP);
    wait_ev(`I2CM_E_STP);
    for (int i = 0; i < 3; i++) check(32'(u_slave.wr_q[2 + i]), 32'(8'(48 + i) ^ 8'hA0));
    report_and_stop();
  end
endmodule

// ===== verification/i2cm_slave_model.sv
/*
 Behavioural two-wire slave: acks its own address, keeps written bytes, sends bytes on reads.
 Assumes the bench resolves both lines with pull-ups.
*/
`timescale 1ns/1ps
module i2cm_slave_model #(
  parameter logic [6:0] SLV_ADDR = 7'h5A
) (
  input  wire logic scl,
  input  wire logic sda,
  input  wire logic slow,
  output logic      sda_low,
  output logic      scl_low
);
  // ----------------------------------------
  // Frame tracking
  // ----------------------------------------
  logic [7:0] sh;
  logic [7:0] abyte;
  logic [7:0] rbyte;
  logic [7:0] wr_q [$];
  logic       mack_q [$];
  logic       sel;
  logic       rd;
  int         bitn = -1;
  int         frame;
  int         n_starts;
  int         n_stops;
  initial sda_low = 1'b0;
  initial scl_low = 1'b0;
  always @(negedge sda) if (scl === 1'b1) begin
    bitn = -1;
    frame = 0;
    sel = 1'b0;
    rd = 1'b0;
    n_starts++;
  end
  always @(posedge sda) if (scl === 1'b1) begin
    sel = 1'b0;
    n_stops++;
  end
  always @(posedge scl) begin
    if (bitn >= 0 && bitn < 8) sh = {sh[6:0], sda};
    if (bitn == 8 && rd && frame > 0) begin
      mack_q.push_back(sda);
      if (sda) sel = 1'b0;
    end
  end
  always @(negedge scl) begin
    bitn = bitn + 1;
    sda_low = 1'b0;
    if (bitn == 9) begin
      bitn = 0;
      frame = frame + 1;
    end
    rbyte = 8'hC3 + 8'(frame);
    if (bitn == 8 && frame == 0) begin
      abyte = sh;
      sel = (sh[7:1] == SLV_ADDR);
      rd = sh[0];
      sda_low = sel;
    end else if (bitn == 8 && sel && !rd) begin
      wr_q.push_back(sh);
      sda_low = 1'b1;
    end else if (bitn < 8 && sel && rd && frame > 0) begin
      sda_low = ~rbyte[7 - bitn];
    end
    if (slow) begin
      scl_low = 1'b1;
      #1500;
      scl_low = 1'b0;
    end
  end
endmodule
